// >>> core/tqd_defines.svh
`ifndef TQD_DEFINES_SVH
`define TQD_DEFINES_SVH

// Register byte offsets.
`define TQD_OFS_CTRL 8'h00
`define TQD_OFS_CTRL2 8'h04
`define TQD_OFS_DIV 8'h08
`define TQD_OFS_XSEL 8'h0C
`define TQD_OFS_YSEL 8'h10
`define TQD_OFS_ZSEL 8'h14
`define TQD_OFS_XCNT 8'h18
`define TQD_OFS_YCNT 8'h1C
`define TQD_OFS_ZCNT 8'h20
`define TQD_OFS_EVCNT 8'h24
`define TQD_OFS_IRQST 8'h28
`define TQD_OFS_IRQMSK 8'h2C

// Field positions and widths.
`define TQD_CTRL_EN_LSB 0
`define TQD_CTRL_THR_LSB 8
`define TQD_CTRL_CLR_BIT 16
`define TQD_PIN_W 4
`define TQD_DIV_W 10
`define TQD_STEP_W 16
`define TQD_EVT_W 8

// Reset values.
`define TQD_RST_EN 3'h0
`define TQD_RST_THR 8'h00
`define TQD_RST_MODE 3'h0
`define TQD_RST_DIV 10'h000
`define TQD_RST_SEL 8'h10
`define TQD_RST_MASK 1'h0

// Timing: clock rate and highest sampling rate in MHz, least divider, filter length in samples.
`define TQD_CLK_MHZ 200
`define TQD_SAMPLE_MAX_MHZ 16
`define TQD_MIN_DIV ((`TQD_CLK_MHZ + `TQD_SAMPLE_MAX_MHZ - 1) / `TQD_SAMPLE_MAX_MHZ)
`define TQD_FILT_LEN 3

`endif

// >>> core/tqd_pkg.sv
`include "tqd_defines.svh"

package tqd_pkg;

	typedef enum logic
	{
		TQD_MODE_QUAD = 1'b0,
		TQD_MODE_EDGE = 1'b1
	} tqd_mode_t;

	typedef struct packed
	{
		logic [`TQD_PIN_W-1:0] pin_b;
		logic [`TQD_PIN_W-1:0] pin_a;
	} tqd_pinsel_t;

	typedef struct packed
	{
		logic [`TQD_EVT_W-1:0] threshold;
		logic [2:0] enable;
	} tqd_ctrl_t;

endpackage : tqd_pkg

// >>> core/tqd_top.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tqd_defines.svh"

// Summary of operation
// - Signed 16-bit step counter per axis.
// - Shared 8-bit counter of edges on enabled axes.
// - Quadrature direction from which channel leads.
// - Per-axis quadrature or every-edge counting.
// - Simultaneous edges count as one event.
// - Filter rejects pulses under three samples.
// - Disabled axis clears its step counter.
// - Event counter counts all modes, once.
// - Divider sets sampling period, max 16 MHz.
// - Low-power system clock bypasses divider.
// - Threshold raises interrupt; counting continues.
// - Software selects pins per axis pair.
// - Write clears pending interrupt, event counter.
// - Counters readable over the bus anytime.
// - Interrupt usable as movement wake-up.
module tqd_top #(
	parameter int NUM_GPIO = 16,
	parameter int ADDR_W = 8
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [NUM_GPIO-1:0] gpio_in,
	input wire logic low_power_clock,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);

	localparam int NPAD = 1 << `TQD_PIN_W;
	localparam logic [`TQD_DIV_W-1:0] MIN_DIV = `TQD_DIV_W'(`TQD_MIN_DIV);

	logic [NUM_GPIO-1:0] s1_q, s2_q, s3_q, pin_q;
	logic [NPAD-1:0] pin_pad;
	tqd_pkg::tqd_ctrl_t ctrl_q;
	tqd_pkg::tqd_mode_t mode_q [3];
	tqd_pkg::tqd_pinsel_t sel_q [3];
	logic [`TQD_DIV_W-1:0] div_q, div_cnt_q, period;
	logic tick;
	logic [5:0] raw, filt_q, filt_d, edge_c;
	logic [`TQD_FILT_LEN-2:0] hist_q [6];
	logic [`TQD_STEP_W-1:0] step_q [3];
	logic [`TQD_EVT_W-1:0] evt_q, evt_inc;
	logic any_edge, evt_clr, thr_hit;
	logic pend_q, pend_d, mask_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q, wmask, wval, rd_c;
	logic aw_have_q, w_have_q, wr_en, wr_ok, rd_ok;

	// Three-stage pin sampler; a level is accepted when stages two and three agree.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end
		else if (clk_en)
		begin
			s1_q <= gpio_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
		end
	end

	assign pin_pad = NPAD'(pin_q);

	// Sampling tick from the programmable divider.
	assign period = (div_q < MIN_DIV) ? MIN_DIV : div_q;
	assign tick = low_power_clock || (div_cnt_q >= period - 1'b1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			div_cnt_q <= '0;
		else if (clk_en)
			div_cnt_q <= tick ? '0 : div_cnt_q + 1'b1;
	end

	// Channel filters and edge detectors, two channels per axis.
	genvar c;
	generate
		for (c = 0; c < 6; c++)
		begin : g_chan
			assign raw[c] = (c % 2 == 0) ? pin_pad[sel_q[c/2].pin_a]
				: pin_pad[sel_q[c/2].pin_b];
			always_comb
			begin
				filt_d[c] = filt_q[c];
				if (tick && (hist_q[c] == {(`TQD_FILT_LEN-1){raw[c]}}))
					filt_d[c] = raw[c];
			end
			assign edge_c[c] = filt_d[c] ^ filt_q[c];
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					hist_q[c] <= '0;
					filt_q[c] <= 1'b0;
				end
				else if (clk_en)
				begin
					if (tick)
						hist_q[c] <= {hist_q[c][`TQD_FILT_LEN-3:0], raw[c]};
					filt_q[c] <= filt_d[c];
				end
			end
		end
	endgenerate

	// Per-axis step counters.
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_axis
			logic ea, eb, up;
			assign ea = edge_c[2*g];
			assign eb = edge_c[2*g+1];
			assign up = filt_d[2*g] ^ filt_q[2*g+1];
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					step_q[g] <= '0;
				else if (clk_en)
				begin
					if (!ctrl_q.enable[g])
						step_q[g] <= '0;
					else if (mode_q[g] == tqd_pkg::TQD_MODE_EDGE)
					begin
						if (ea || eb)
							step_q[g] <= step_q[g] + 1'b1;
					end
					else if (ea ^ eb)
					begin
						if (up)
							step_q[g] <= step_q[g] + 1'b1;
						else
							step_q[g] <= step_q[g] - 1'b1;
					end
				end
			end
		end
	endgenerate

	// Shared event counter and threshold interrupt.
	assign any_edge = |(edge_c & {{2{ctrl_q.enable[2]}},
		{2{ctrl_q.enable[1]}}, {2{ctrl_q.enable[0]}}});
	assign evt_inc = (evt_clr ? '0 : evt_q) + 1'b1;
	assign thr_hit = any_edge && (evt_inc == ctrl_q.threshold);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			evt_q <= '0;
		else if (clk_en)
		begin
			if (any_edge)
				evt_q <= evt_inc;
			else if (evt_clr)
				evt_q <= '0;
		end
	end

	assign pend_d = thr_hit
		| (pend_q & ~(wr_en && awaddr_q == `TQD_OFS_IRQST && wval[0]));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_q <= 1'b0;
			irq <= 1'b0;
		end
		else if (clk_en)
		begin
			pend_q <= pend_d;
			irq <= pend_d & mask_q;
		end
	end

	// Bus write channels: each is taken one cycle after its valid.
	assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
	for (genvar b = 0; b < 4; b++)
	begin : g_strb
		assign wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			aw_have_q <= 1'b0;
			awaddr_q <= '0;
		end
		else if (clk_en)
		begin
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_have_q;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
			end
			else if (wr_en)
				aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b0;
			w_have_q <= 1'b0;
			wdata_q <= '0;
		end
		else if (clk_en)
		begin
			s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_have_q;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			else if (wr_en)
				w_have_q <= 1'b0;
		end
	end

	always_comb
	begin
		wr_ok = 1'b1;
		case (awaddr_q)
			`TQD_OFS_CTRL, `TQD_OFS_CTRL2, `TQD_OFS_DIV, `TQD_OFS_XSEL,
			`TQD_OFS_YSEL, `TQD_OFS_ZSEL, `TQD_OFS_IRQST,
			`TQD_OFS_IRQMSK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else if (clk_en)
		begin
			if (wr_en)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	logic [31:0] strb_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			strb_q <= '0;
		else if (clk_en && s_axi_wvalid && s_axi_wready)
			strb_q <= wmask;
	end
	assign wval = wdata_q & strb_q;

	assign evt_clr = wr_en && awaddr_q == `TQD_OFS_CTRL
		&& wval[`TQD_CTRL_CLR_BIT];

	// Configuration registers.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q.enable <= `TQD_RST_EN;
			ctrl_q.threshold <= `TQD_RST_THR;
		end
		else if (clk_en && wr_en && awaddr_q == `TQD_OFS_CTRL)
		begin
			ctrl_q.enable <= (ctrl_q.enable & ~strb_q[2:0]) | wval[2:0];
			ctrl_q.threshold <= (ctrl_q.threshold
				& ~strb_q[`TQD_CTRL_THR_LSB +: `TQD_EVT_W])
				| wval[`TQD_CTRL_THR_LSB +: `TQD_EVT_W];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 3; i++)
			begin
				mode_q[i] <= tqd_pkg::tqd_mode_t'(`TQD_RST_MODE >> i);
				sel_q[i] <= `TQD_RST_SEL;
			end
		end
		else if (clk_en && wr_en)
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (awaddr_q == `TQD_OFS_CTRL2 && strb_q[0])
					mode_q[i] <= tqd_pkg::tqd_mode_t'(wval[i]);
				if (awaddr_q == ADDR_W'(`TQD_OFS_XSEL + 4 * i) && strb_q[0])
					sel_q[i] <= wval[7:0];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_q <= `TQD_RST_DIV;
			mask_q <= `TQD_RST_MASK;
		end
		else if (clk_en && wr_en)
		begin
			if (awaddr_q == `TQD_OFS_DIV)
				div_q <= (div_q & ~strb_q[`TQD_DIV_W-1:0])
					| wval[`TQD_DIV_W-1:0];
			if (awaddr_q == `TQD_OFS_IRQMSK && strb_q[0])
				mask_q <= wval[0];
		end
	end

	// Read channel; counters are readable at any time.
	always_comb
	begin
		rd_c = '0;
		rd_ok = 1'b1;
		case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
			`TQD_OFS_CTRL: rd_c = {16'h0, ctrl_q.threshold, 5'h0, ctrl_q.enable};
			`TQD_OFS_CTRL2: rd_c = {29'h0, mode_q[2], mode_q[1], mode_q[0]};
			`TQD_OFS_DIV: rd_c = {22'h0, div_q};
			`TQD_OFS_XSEL: rd_c = {24'h0, sel_q[0]};
			`TQD_OFS_YSEL: rd_c = {24'h0, sel_q[1]};
			`TQD_OFS_ZSEL: rd_c = {24'h0, sel_q[2]};
			`TQD_OFS_XCNT: rd_c = {16'h0, step_q[0]};
			`TQD_OFS_YCNT: rd_c = {16'h0, step_q[1]};
			`TQD_OFS_ZCNT: rd_c = {16'h0, step_q[2]};
			`TQD_OFS_EVCNT: rd_c = {24'h0, evt_q};
			`TQD_OFS_IRQST: rd_c = {31'h0, pend_q};
			`TQD_OFS_IRQMSK: rd_c = {31'h0, mask_q};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end
		else if (clk_en)
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_c;
				s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule : tqd_top

// >>> test/tqd_enc_model.sv
`timescale 1ns/1ps
// Encoder on the far side: axis n drives pins 2n (A) and 2n+1 (B).
module tqd_enc_model (
	input wire logic aclk,
	output logic [5:0] pins
);
	logic [1:0] ph [3];
	initial
	begin
		pins = 6'h00;
		ph = '{2'h0, 2'h0, 2'h0};
	end
	// Moves an axis one quarter period; A leads going forward.
	task step(input int ax, input bit fwd);
		ph[ax] = fwd ? ph[ax] + 2'h1 : ph[ax] - 2'h1;
		@(posedge aclk);
		pins[2*ax] <= ph[ax] == 2'h1 || ph[ax] == 2'h2;
		pins[2*ax+1] <= ph[ax][1];
		repeat (15) @(posedge aclk);
	endtask : step
	// Sets raw pin levels and holds them for n cycles.
	task set(input logic [5:0] v, input int n);
		@(posedge aclk);
		pins <= v;
		repeat (n) @(posedge aclk);
	endtask : set
endmodule : tqd_enc_model

// >>> test/tqd_chk.sv
`timescale 1ns/1ps
module tqd_chk #(
	parameter int ADDR_W = 8
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic rd_bad_q;
	logic wr_bad_q;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Remembers whether the accepted address falls outside the map.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_bad_q <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_bad_q <= s_axi_araddr > 8'h2C || s_axi_araddr[1:0] != 2'h0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wr_bad_q <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			wr_bad_q <= s_axi_awaddr > 8'h2C || s_axi_awaddr[1:0] != 2'h0;
	end
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held longer than one cycle");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready held longer than one cycle");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write reply dropped");
	a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid) else $error("read reply not retired");
	a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("write reply not retired");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready |->
		##[1:3] s_axi_bvalid) else $error("write answer late");
	a_rd_error: assert property (s_axi_rvalid |->
		(rd_bad_q ? s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0
		: s_axi_rresp == 2'h0)) else $error("read response wrong");
	a_wr_error: assert property (s_axi_bvalid |->
		s_axi_bresp == (wr_bad_q ? 2'h2 : 2'h0))
		else $error("write response wrong");
endmodule : tqd_chk

bind tqd_top tqd_chk #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

// >>> test/tb_three_axis_quadrature_decoder.sv
`timescale 1ns/1ps
`include "tqd_defines.svh"
module tb_three_axis_quadrature_decoder;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clk_en = 1'b1;
	logic lpc = 1'b1;
	logic [5:0] pins;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rr_q, br_q;
	int miscompares = 0;
	int total_checks = 0;
	always #2.5 aclk = ~aclk;
	tqd_enc_model enc (.aclk(aclk), .pins(pins));
	tqd_top DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.gpio_in({10'h000, pins}), .low_power_clock(lpc),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			n++;
		end
		while (bvalid !== 1'b1 && n < 40);
		br_q = bresp;
		bready <= 1'b0;
		chk("write done", 32'h1, {31'h0, n < 40});
		if (n >= 40)
			wrap_up();
	endtask : wr
	task rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 40);
		rd_q = rdata;
		rr_q = rresp;
		rready <= 1'b0;
		if (n >= 40)
		begin
			chk("read done", 32'h1, 32'h0);
			wrap_up();
		end
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk("register", e, rd_q);
	endtask : rc
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`TQD_OFS_CTRL, 32'h0);
		rc(`TQD_OFS_CTRL2, 32'h0);
		rc(`TQD_OFS_DIV, 32'h0);
		rc(`TQD_OFS_XSEL, 32'h10);
		rc(`TQD_OFS_IRQMSK, 32'h0);
		rc(`TQD_OFS_XCNT, 32'h0);
		rd(8'h30);
		chk("read resp", 32'h2, {30'h0, rr_q});
		wr(8'h30, 32'hFFFF_FFFF, 4'hF);
		chk("write resp", 32'h2, {30'h0, br_q});
		$display("test reset done");
		wr(`TQD_OFS_YSEL, 32'h32, 4'h1);
		wr(`TQD_OFS_ZSEL, 32'h54, 4'h1);
		wr(`TQD_OFS_CTRL2, 32'h2, 4'h1);
		wr(`TQD_OFS_IRQMSK, 32'h1, 4'h1);
		wr(`TQD_OFS_CTRL, 32'h0603, 4'h3);
		repeat (4) enc.step(0, 1'b1);
		rc(`TQD_OFS_XCNT, 32'h4);
		repeat (6) enc.step(0, 1'b0);
		rd(`TQD_OFS_XCNT);
		chk("x count", 32'hFFFE, {16'h0, rd_q[15:0]});
		rc(`TQD_OFS_EVCNT, 32'hA);
		$display("test quadrature done");
		enc.set(6'h0F, 15);
		enc.set(6'h0B, 15);
		rc(`TQD_OFS_YCNT, 32'h2);
		rc(`TQD_OFS_EVCNT, 32'hC);
		chk("irq", 32'h1, {31'h0, irq});
		rc(`TQD_OFS_IRQST, 32'h1);
		wr(`TQD_OFS_IRQST, 32'h1, 4'h1);
		repeat (3) @(posedge aclk);
		chk("irq", 32'h0, {31'h0, irq});
		rc(`TQD_OFS_EVCNT, 32'hC);
		$display("test edges and interrupt done");
		enc.set(6'h0A, 1);
		enc.set(6'h0B, 15);
		rc(`TQD_OFS_EVCNT, 32'hC);
		enc.set(6'h0A, 2);
		enc.set(6'h0B, 15);
		rc(`TQD_OFS_EVCNT, 32'hE);
		rc(`TQD_OFS_XCNT, 32'hFFFE);
		@(posedge aclk);
		lpc <= 1'b0;
		enc.set(6'h0F, 20);
		enc.set(6'h0B, 100);
		rc(`TQD_OFS_EVCNT, 32'hE);
		enc.set(6'h0F, 100);
		rc(`TQD_OFS_YCNT, 32'h3);
		rc(`TQD_OFS_EVCNT, 32'hF);
		$display("test filter and divider done");
		@(posedge aclk);
		lpc <= 1'b1;
		clk_en <= 1'b0;
		enc.set(6'h0B, 10);
		enc.set(6'h0F, 10);
		@(posedge aclk);
		clk_en <= 1'b1;
		rc(`TQD_OFS_YCNT, 32'h3);
		rc(`TQD_OFS_EVCNT, 32'hF);
		$display("test freeze done");
		wr(`TQD_OFS_CTRL, 32'h0607, 4'h3);
		repeat (2) enc.step(2, 1'b0);
		rc(`TQD_OFS_ZCNT, 32'hFFFE);
		rc(`TQD_OFS_EVCNT, 32'h11);
		wr(`TQD_OFS_DIV, 32'h2AB, 4'h1);
		rc(`TQD_OFS_DIV, 32'hAB);
		$display("test z axis and divider write done");
		wr(`TQD_OFS_CTRL, 32'h0606, 4'h3);
		rc(`TQD_OFS_XCNT, 32'h0);
		wr(`TQD_OFS_CTRL, 32'h0001_0606, 4'h7);
		rc(`TQD_OFS_EVCNT, 32'h0);
		$display("test disable and clear done");
		wrap_up();
	end
endmodule : tb_three_axis_quadrature_decoder
